/* hdl/ulf_line_control.sv */
`timescale 1ns/1ps
// Function
// - divisor_latch_access 1 maps shared data addresses to baud divisor, 0 maps only the data address to the transceiver.
// - break_force drives the line low starting at the next bit boundary.
// - a character in the shifter is dropped when a break begins.
// - the transmit queue is flushed just before the line first goes low.
// - after break clears, the line idles from the next bit boundary and queued data starts at the boundary after it.
// - parity_error_force with parity_on sends an inverted parity bit.
// - parity_sense 0 without multidrop gives odd parity both ways.
// - parity_sense 1 without multidrop gives even parity both ways.
// - parity_on adds a parity bit on transmit and checks it on receive.
// - parity_on 0 sends no parity bit and checks none.
// - multidrop sends parity_sense itself as the parity bit, space or mark.
// - multidrop receive always checks for space parity.
// - low two bits of char_format pick five to eight data bits.
// - bit 2 of char_format picks one or two stop bits.
// - in multidrop, parity_sense clears after the first character is sent.
module ulf_line_control (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic divisor_sel_o,
  output logic tx_full_o,
  // line and timing
  input wire logic baud_tick_i,
  input wire logic multidrop_i,
  input wire logic rxd_i,
  output logic txd_o,
  // status
  output logic tx_holding_empty_o,
  output ulf_pkg::ulf_rx_type rx_o,
  output logic rx_valid_o
);
  import ulf_pkg::*;

  ulf_lctl_type lctl_reg;
  ulf_tx_state_type state_reg;
  logic [3:0] tick_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic par_reg;
  logic stop_first_reg;
  logic txd_reg;
  logic [7:0] rdata_reg;
  logic [2:0] rx_sync_reg;
  logic rx_lvl_reg;
  logic rx_act_reg;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic rx_par_reg;
  ulf_rx_type rx_reg;
  logic rx_valid_reg;
  logic [7:0] head;
  logic fifo_empty;

  // shared address decode
  wire shared_hit = (addr_i == ULF_ADDR_DATA) || (addr_i == ULF_ADDR_AUX);
  wire lctl_wr = wr_i && (addr_i == ULF_ADDR_LCTL);
  wire thr_wr = wr_i && addr_i == ULF_ADDR_DATA && !lctl_reg.divisor_latch_access;
  assign divisor_sel_o = (wr_i || rd_i) && shared_hit && lctl_reg.divisor_latch_access;

  // transmit timing
  wire bit_edge = baud_tick_i && tick_reg == ULF_TICKS_LAST;
  wire brk_start = bit_edge && lctl_reg.break_force && state_reg != ULF_BREAK;
  wire flush = brk_start;
  wire load = bit_edge && state_reg == ULF_IDLE && !lctl_reg.break_force && !fifo_empty;
  wire [3:0] last_bit = ulf_last_bit(lctl_reg.data_len);
  wire head_xor = ulf_data_xor(head, lctl_reg.data_len);
  wire par_good = multidrop_i ? lctl_reg.parity_sense : (head_xor ^ !lctl_reg.parity_sense);
  wire par_send = par_good ^ lctl_reg.parity_error_force;
  wire data_done = bit_edge && state_reg == ULF_DATA && bit_reg == last_bit;
  wire char_done = bit_edge && state_reg == ULF_STOP && !stop_first_reg;

  ulf_tx_fifo #(
    .WIDTH(8),
    .DEPTH(ULF_FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .push_i(thr_wr),
    .wdata_i(wdata_i),
    .full_o(tx_full_o),
    .pop_i(load),
    .flush_i(flush),
    .head_o(head),
    .empty_o(fifo_empty)
  );

  // register write; hardware clears parity_sense after a multidrop character
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lctl_reg <= ULF_LCTL_RESET;
    end else if (lctl_wr) begin
      lctl_reg <= wdata_i;
    end else if (char_done && multidrop_i) begin
      lctl_reg.parity_sense <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      rdata_reg <= (addr_i == ULF_ADDR_LCTL) ? lctl_reg :
                   (addr_i == ULF_ADDR_DATA && !lctl_reg.divisor_latch_access) ? rx_reg.data : 8'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tick_reg <= 4'h0;
    end else if (baud_tick_i) begin
      tick_reg <= tick_reg + 4'h1;
    end
  end

  // transmitter
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= ULF_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      par_reg <= 1'b0;
      stop_first_reg <= 1'b0;
    end else if (brk_start) begin
      state_reg <= ULF_BREAK;
    end else if (bit_edge) begin
      case (state_reg)
        ULF_IDLE: begin
          if (load) begin
            state_reg <= ULF_START;
            shift_reg <= head;
            par_reg <= par_send;
          end
        end
        ULF_START: begin
          state_reg <= ULF_DATA;
          bit_reg <= 4'h0;
        end
        ULF_DATA: begin
          shift_reg <= {1'b0, shift_reg[7:1]};
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg == last_bit) begin
            state_reg <= lctl_reg.parity_on ? ULF_PARITY : ULF_STOP;
            stop_first_reg <= lctl_reg.stop_two;
          end
        end
        ULF_PARITY: begin
          state_reg <= ULF_STOP;
        end
        ULF_STOP: begin
          stop_first_reg <= 1'b0;
          if (!stop_first_reg) begin
            state_reg <= ULF_IDLE;
          end
        end
        ULF_BREAK: begin
          if (!lctl_reg.break_force) begin
            state_reg <= ULF_IDLE;
          end
        end
        default: begin
          state_reg <= ULF_IDLE;
        end
      endcase
    end
  end

  wire tx_line = (state_reg == ULF_START || state_reg == ULF_BREAK) ? 1'b0 :
                 (state_reg == ULF_DATA) ? shift_reg[0] :
                 (state_reg == ULF_PARITY) ? par_reg : 1'b1;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      txd_reg <= 1'b1;
    end else begin
      txd_reg <= tx_line;
    end
  end

  assign txd_o = txd_reg;
  assign tx_holding_empty_o = fifo_empty;
  assign rdata_o = rdata_reg;

  // receiver
  // index of the stop bit: start, data, optional parity
  wire [3:0] rx_total = last_bit + 4'h2 + {3'h0, lctl_reg.parity_on};
  wire rx_mid = baud_tick_i && rx_act_reg && rx_tick_reg == ULF_MID_TICK;
  wire rx_end = rx_mid && rx_idx_reg == rx_total;
  wire [7:0] rx_aligned = rx_shift_reg >> (2'h3 - lctl_reg.data_len);
  wire rx_xor = ulf_data_xor(rx_aligned, lctl_reg.data_len);
  wire rx_exp = multidrop_i ? 1'b0 : (rx_xor ^ !lctl_reg.parity_sense);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_sync_reg <= 3'h7;
      rx_lvl_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rxd_i};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_lvl_reg <= rx_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_act_reg <= 1'b0;
      rx_tick_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg <= 1'b0;
      rx_reg <= '0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_act_reg) begin
        if (baud_tick_i && !rx_lvl_reg) begin
          rx_act_reg <= 1'b1;
          rx_tick_reg <= 4'h0;
          rx_idx_reg <= 4'h0;
        end
      end else if (baud_tick_i) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
        if (rx_tick_reg == ULF_MID_TICK) begin
          rx_idx_reg <= rx_idx_reg + 4'h1;
          if (rx_idx_reg == 4'h0 && rx_lvl_reg) begin
            rx_act_reg <= 1'b0;
          end else if (rx_idx_reg != 4'h0 && rx_idx_reg <= last_bit + 4'h1) begin
            rx_shift_reg <= {rx_lvl_reg, rx_shift_reg[7:1]};
          end else if (rx_idx_reg != rx_total) begin
            rx_par_reg <= rx_lvl_reg;
          end
          if (rx_end) begin
            rx_act_reg <= 1'b0;
            rx_valid_reg <= 1'b1;
            rx_reg.data <= rx_aligned;
            rx_reg.parity_err <= lctl_reg.parity_on && (rx_par_reg != rx_exp);
            rx_reg.frame_err <= !rx_lvl_reg;
          end
        end
      end
    end
  end

  assign rx_o = rx_reg;
  assign rx_valid_o = rx_valid_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_break_entry;
    brk_start ##1 (state_reg == ULF_BREAK && tx_holding_empty_o);
  endsequence

  property p_break_low;
    brk_start |-> s_break_entry ##1 !txd_o;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break did not drive line low");

  property p_break_waits_edge;
    lctl_reg.break_force && state_reg != ULF_BREAK && !bit_edge |=> state_reg != ULF_BREAK;
  endproperty
  a_break_waits_edge: assert property (p_break_waits_edge) else $error("break began off a boundary");

  property p_flush_at_break;
    flush |-> bit_edge && lctl_reg.break_force ##1 fifo_empty;
  endproperty
  a_flush_at_break: assert property (p_flush_at_break) else $error("queue flushed without break");

  property p_abort_char;
    lctl_reg.break_force && bit_edge && state_reg == ULF_DATA |=> state_reg == ULF_BREAK;
  endproperty
  a_abort_char: assert property (p_abort_char) else $error("character kept during break");

  property p_resume;
    state_reg == ULF_BREAK && !lctl_reg.break_force && bit_edge |=> state_reg == ULF_IDLE;
  endproperty
  a_resume: assert property (p_resume) else $error("no recovery after break");

  property p_force_err;
    load && lctl_reg.parity_error_force && !multidrop_i |=> par_reg == $past(head_xor ^ lctl_reg.parity_sense);
  endproperty
  a_force_err: assert property (p_force_err) else $error("forced parity not wrong");

  property p_parity_sense;
    load && !lctl_reg.parity_error_force && !multidrop_i |=> (ulf_data_xor(shift_reg, lctl_reg.data_len) ^ par_reg)
      == !$past(lctl_reg.parity_sense);
  endproperty
  a_parity_sense: assert property (p_parity_sense) else $error("odd or even parity wrong");

  property p_multidrop_bit;
    load && multidrop_i && !lctl_reg.parity_error_force |=> par_reg == $past(lctl_reg.parity_sense);
  endproperty
  a_multidrop_bit: assert property (p_multidrop_bit) else $error("multidrop parity not fixed");

  property p_data_len;
    data_done && !brk_start |=> state_reg == (lctl_reg.parity_on ? ULF_PARITY : ULF_STOP) && bit_reg == last_bit + 4'h1;
  endproperty
  a_data_len: assert property (p_data_len) else $error("wrong data length or parity slot");

  property p_sense_clear;
    char_done && multidrop_i && !lctl_wr |=> !lctl_reg.parity_sense;
  endproperty
  a_sense_clear: assert property (p_sense_clear) else $error("parity_sense not cleared");

  property p_rx_space;
    rx_end && multidrop_i |=> rx_reg.parity_err == (lctl_reg.parity_on && $past(rx_par_reg));
  endproperty
  a_rx_space: assert property (p_rx_space) else $error("multidrop receive parity wrong");

  property p_div_access_blocks;
    wr_i && addr_i == ULF_ADDR_DATA && lctl_reg.divisor_latch_access |-> divisor_sel_o && !thr_wr;
  endproperty
  a_div_access_blocks: assert property (p_div_access_blocks) else $error("divisor access reached data");
endmodule

/* hdl/ulf_pkg.sv */
package ulf_pkg;

  // shared I/O addresses of the channel
  localparam logic [7:0] ULF_ADDR_DATA = 8'hc0;
  localparam logic [7:0] ULF_ADDR_AUX = 8'hc1;
  localparam logic [7:0] ULF_ADDR_LCTL = 8'hc3;
  localparam logic [7:0] ULF_LCTL_RESET = 8'h00;

  // line_format_control field positions
  localparam int ULF_BIT_DIV_ACCESS = 7;
  localparam int ULF_BIT_BREAK = 6;
  localparam int ULF_BIT_FORCE_ERR = 5;
  localparam int ULF_BIT_SENSE = 4;
  localparam int ULF_BIT_PEN = 3;
  localparam int ULF_BIT_STOP2 = 2;

  // baud ticks per bit and the mid-bit sample point
  localparam logic [3:0] ULF_TICKS_LAST = 4'hf;
  localparam logic [3:0] ULF_MID_TICK = 4'h7;
  localparam int ULF_FIFO_DEPTH = 16;

  typedef struct packed {
    logic divisor_latch_access;
    logic break_force;
    logic parity_error_force;
    logic parity_sense;
    logic parity_on;
    logic stop_two;
    logic [1:0] data_len;
  } ulf_lctl_type;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } ulf_rx_type;

  typedef enum logic [2:0] {
    ULF_IDLE = 3'h0,
    ULF_START = 3'h1,
    ULF_DATA = 3'h3,
    ULF_PARITY = 3'h2,
    ULF_STOP = 3'h6,
    ULF_BREAK = 3'h7
  } ulf_tx_state_type;

  // xor of the active data bits
  function automatic logic ulf_data_xor(input logic [7:0] d, input logic [1:0] len);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - len);
    return ^(d & m);
  endfunction

  // number of data bits minus one
  function automatic logic [3:0] ulf_last_bit(input logic [1:0] len);
    return 4'h4 + {2'h0, len};
  endfunction

endpackage

/* hdl/ulf_tx_fifo.sv */
`timescale 1ns/1ps
module ulf_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // write side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic full_o,
  // read side
  input wire logic pop_i,
  input wire logic flush_i,
  output logic [WIDTH-1:0] head_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] head_reg;

  wire do_push = push_i && !full_o && !flush_i;
  wire do_pop = pop_i && !empty_o && !flush_i;
  wire [AW-1:0] rptr_next = flush_i ? wptr_reg : (do_pop ? AW'(rptr_reg + 1'b1) : rptr_reg);

  assign full_o = (count_reg == (AW+1)'(DEPTH));
  assign empty_o = (count_reg == '0);
  assign head_o = head_reg;

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wptr_reg] <= wdata_i;
    end
    // head bypasses the array when the slot is written this cycle
    head_reg <= (do_push && wptr_reg == rptr_next) ? wdata_i : mem[rptr_next];
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || flush_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= AW'(wptr_reg + 1'b1);
      end
      rptr_reg <= rptr_next;
      count_reg <= (AW+1)'(count_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop});
    end
  end
endmodule

/* test/ulf_far_end.sv */
`timescale 1ns/1ps
module ulf_far_end #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input wire logic clock_i,
  // line from the device and its format
  input wire logic txd_i,
  input wire logic [1:0] data_len_i,
  input wire logic parity_on_i,
  // line into the device
  output logic rxd_o
);
  logic [7:0] cap_data;
  logic cap_par;
  logic cap_stop;
  int cap_span;
  int frames_seen = 0;
  int cyc = 0;
  int fall_cyc = 0;

  always @(posedge clock_i) cyc <= cyc + 1;

  // decode each frame, sampling mid-bit from the start edge, away from the launching edge
  initial begin
    rxd_o = 1'b1;
    forever begin
      @(negedge clock_i);
      if (txd_i === 1'b0) begin
        cap_span = cyc - fall_cyc;
        fall_cyc = cyc;
        cap_data = 8'h00;
        repeat (BIT_CLKS / 2) @(negedge clock_i);
        for (int k = 0; k < 5 + data_len_i; k++) begin
          repeat (BIT_CLKS) @(negedge clock_i);
          cap_data[k] = txd_i;
        end
        if (parity_on_i) begin
          repeat (BIT_CLKS) @(negedge clock_i);
          cap_par = txd_i;
        end
        repeat (BIT_CLKS) @(negedge clock_i);
        cap_stop = txd_i;
        frames_seen++;
        while (txd_i !== 1'b1) @(negedge clock_i);
      end
    end
  end

  // one frame into the device, then a long idle so a bad stop settles
  task automatic send(input logic [7:0] d, input logic pb, input logic sb);
    rxd_o = 1'b0;
    repeat (BIT_CLKS) @(negedge clock_i);
    for (int k = 0; k < 5 + data_len_i; k++) begin
      rxd_o = d[k];
      repeat (BIT_CLKS) @(negedge clock_i);
    end
    if (parity_on_i) begin
      rxd_o = pb;
      repeat (BIT_CLKS) @(negedge clock_i);
    end
    rxd_o = sb;
    repeat (BIT_CLKS) @(negedge clock_i);
    rxd_o = 1'b1;
    repeat (BIT_CLKS * 12) @(negedge clock_i);
  endtask
endmodule

/* test/uart_line_format_control_tb.sv */
`timescale 1ns/1ps
module uart_line_format_control_tb;
  import ulf_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic baud_tick_i = 1'b0;
  logic multidrop_i = 1'b0;
  logic [7:0] rdata_o;
  logic divisor_sel_o, tx_full_o, txd_o, tx_holding_empty_o, rx_valid_o, rxd, sel;
  ulf_rx_type rx_o, rx_seen;
  logic [7:0] lctl = 8'h00;
  logic [7:0] rv;
  logic [7:0] mtab [6] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h08, 8'h18};
  int errors = 0;
  int samples_checked = 0;

  always #12.5 clock_i = ~clock_i;
  // a tick every other clock: 32 clocks a bit
  always @(negedge clock_i) baud_tick_i <= ~baud_tick_i;

  ulf_line_control uut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .divisor_sel_o(divisor_sel_o), .tx_full_o(tx_full_o),
    .baud_tick_i(baud_tick_i), .multidrop_i(multidrop_i), .rxd_i(rxd), .txd_o(txd_o),
    .tx_holding_empty_o(tx_holding_empty_o), .rx_o(rx_o), .rx_valid_o(rx_valid_o));
  ulf_far_end far (.clock_i(clock_i), .txd_i(txd_o), .data_len_i(lctl[1:0]), .parity_on_i(lctl[3]), .rxd_o(rxd));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d, samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic guard(input int t);
    if (t > 4000) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clock_i);
    wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clock_i);
    addr_i = a;
    rd_i = 1'b1;
    #1 sel = divisor_sel_o;
    @(negedge clock_i);
    rd_i = 1'b0;
    rv = rdata_o;
  endtask

  task automatic set_lctl(input logic [7:0] v);
    lctl = v;
    wr(ULF_ADDR_LCTL, v);
  endtask

  task automatic wait_frames(input int n);
    for (int t = 0; far.frames_seen < n; t++) begin
      guard(t);
      @(negedge clock_i);
    end
  endtask

  function automatic logic dxor(input logic [7:0] d, input logic [1:0] len);
    logic x;
    x = 1'b0;
    for (int k = 0; k < 5 + len; k++) x ^= d[k];
    return x;
  endfunction

  task automatic rx_case(input logic [7:0] v, input logic md, input logic [7:0] d, input logic pb,
                         input logic sb, input logic [1:0] exp_err);
    multidrop_i = md;
    set_lctl(v);
    fork
      far.send(d, pb, sb);
      begin
        for (int t = 0; rx_valid_o !== 1'b1; t++) begin
          guard(t);
          @(negedge clock_i);
        end
        rx_seen = rx_o;
      end
    join
    check(rx_seen, {d & (8'hff >> (2'h3 - v[1:0])), exp_err});
    rd(ULF_ADDR_DATA);
    check(rv, d & (8'hff >> (2'h3 - v[1:0])));
  endtask

  initial begin
    logic [7:0] a, b, m;
    logic pa, pb;
    int base, mode;
    repeat (5) @(negedge clock_i);
    srst_i = 1'b0;
    rd(ULF_ADDR_LCTL);
    check(rv, ULF_LCTL_RESET);
    check({txd_o, tx_holding_empty_o, tx_full_o}, 3'h6);
    // shared addresses steer by the access bit
    set_lctl(8'h9b);
    rd(ULF_ADDR_LCTL);
    check({sel, rv}, 9'h09b);
    rd(ULF_ADDR_DATA);
    check({sel, rv}, 9'h100);
    rd(ULF_ADDR_AUX);
    check(sel, 1'b1);
    wr(ULF_ADDR_DATA, 8'h55);
    check(tx_holding_empty_o, 1'b1);
    set_lctl(8'h1b);
    rd(ULF_ADDR_DATA);
    check(sel, 1'b0);
    // every length, stop count and parity mode, two characters back to back
    for (int i = 0; i < 12; i++) begin
      mode = i % 6;
      a = 8'ha7 ^ 8'(i * 13);
      b = 8'h3c + 8'(i);
      m = 8'hff >> (3 - i % 4);
      pa = (mode == 5) ? 1'b1 : (mode >= 4) ? 1'b0 : dxor(a, 2'(i % 4)) ^ (mode == 1);
      pb = (mode >= 4) ? 1'b0 : dxor(b, 2'(i % 4)) ^ (mode == 1);
      multidrop_i = (mode >= 4);
      set_lctl(mtab[mode] | 8'(i % 8));
      base = far.frames_seen;
      wr(ULF_ADDR_DATA, a);
      wr(ULF_ADDR_DATA, b);
      wait_frames(base + 1);
      check(far.cap_data, a & m);
      if (mode != 0) check(far.cap_par, pa);
      wait_frames(base + 2);
      check(far.cap_data, b & m);
      if (mode != 0) check(far.cap_par, pb);
      // start, data, parity, stops, then one idle bit before the next load
      check(far.cap_span, 32 * (8 + i % 4 + (mode != 0) + (i % 8) / 4));
      repeat (96) @(negedge clock_i);
      if (mode == 5) begin
        rd(ULF_ADDR_LCTL);
        check(rv, lctl & 8'hef);
      end
    end
    // break in mid character with two more queued
    multidrop_i = 1'b0;
    set_lctl(8'h03);
    wr(ULF_ADDR_DATA, 8'hff);
    wr(ULF_ADDR_DATA, 8'h81);
    wr(ULF_ADDR_DATA, 8'h42);
    for (int t = 0; txd_o !== 1'b0; t++) begin
      guard(t);
      @(negedge clock_i);
    end
    repeat (40) @(negedge clock_i);
    set_lctl(8'h43);
    check(txd_o, 1'b1);
    repeat (34) @(negedge clock_i);
    check(txd_o, 1'b0);
    check(tx_holding_empty_o, 1'b1);
    wr(ULF_ADDR_DATA, 8'h6e);
    repeat (320) @(negedge clock_i);
    check(txd_o, 1'b0);
    base = far.frames_seen;
    set_lctl(8'h03);
    wait_frames(base + 1);
    check(far.cap_data, 8'h6e);
    check(far.cap_stop, 1'b1);
    repeat (64) @(negedge clock_i);
    // receive checks, bad stop last
    rx_case(8'h1b, 1'b0, 8'h96, 1'b0, 1'b1, 2'h0);
    rx_case(8'h0b, 1'b0, 8'h96, 1'b0, 1'b1, 2'h2);
    rx_case(8'h02, 1'b0, 8'h35, 1'b1, 1'b1, 2'h0);
    rx_case(8'h19, 1'b1, 8'h2a, 1'b0, 1'b1, 2'h0);
    rx_case(8'h19, 1'b1, 8'h2a, 1'b1, 1'b1, 2'h2);
    rx_case(8'h03, 1'b0, 8'ha5, 1'b0, 1'b0, 2'h1);
    tally_and_finish();
  end
endmodule
